//--- logic/cdir_pkg.sv
// shared constants and types for the decode and indirect addressing core
// What this block does
// - window address reaches the register the pointer names; window stores nothing.
// - indirect read of the window through itself returns zero.
// - indirect write of the window through itself stores nothing; flags may change.
// - pointer is five or seven bits wide depending on variant.
// - low five pointer bits pick an address in the lowest 32.
// - unbanked variant reads pointer bits six and five as ones.
// - banked variant uses pointer bits six and five as bank 0 to 3.
// - reset cause sets timeout and powerdown flags per the cause table.
// - clear pin or watchdog wake from sleep performs a reset that keeps accumulator, pointer and timer.
// - general registers are never reset and keep contents over later resets.
// - status resets to 0001 1xxx at power-on, 000q quuu otherwise.
// - byte op destination 0 writes accumulator, 1 writes the file register.
// - xor literal sets accumulator, touches only zero flag, one cycle.
// - xor file combines accumulator with file register, touches only zero flag.
// - decrement or increment skip skips on zero result, no flag change.
// - bit tests skip on set or clear bit, no flag change.
// - rotates shift one bit through carry, touching only carry.
// - call and any write to the low counter byte clear counter bit eight.
// - port register reads take pin levels, not the output latch.
// - direction load 5, 6, 7 copies accumulator to port a, b, c direction.
// - writing the timer register clears the prescaler when assigned to the timer.
// - standby enters sleep and updates both flags; watchdog kick updates them too.
package cdir_pkg;
  localparam logic PTR_BANKED = 1'b1;
  localparam logic [4:0] A_WIN = 5'h00;
  localparam logic [4:0] A_TIMER = 5'h01;
  localparam logic [4:0] A_PC_LOW = 5'h02;
  localparam logic [4:0] A_STATUS = 5'h03;
  localparam logic [4:0] A_PTR = 5'h04;
  localparam logic [4:0] A_PORT0 = 5'h05;
  localparam logic [4:0] A_RAM = 5'h08;
  localparam logic [6:0] RAM_BANK_BASE = 7'h08;
  localparam int RAM_DEPTH = 72;
  localparam int PORT_COUNT = 3;
  localparam logic [8:0] RESET_VECTOR = 9'h1ff;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic [7:0] TIMER_RST = 8'h00;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [8:0] STACK_RST = 9'h000;
  localparam logic [1:0] SYNC_RST = 2'b11;
  localparam logic [11:0] OP_NOP = 12'h000;
  localparam logic [11:0] OP_OPTION = 12'h002;
  localparam logic [11:0] OP_STANDBY = 12'h003;
  localparam logic [11:0] OP_KICK = 12'h004;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_NIBBLE = 1;
  localparam int ST_CARRY = 0;
  localparam int OPT_PRESCALE_WDT = 3;

  typedef enum {CD_RUN, CD_SLEEP} cdir_state_t;

  typedef struct packed {
    logic [7:0] res;
    logic wr_f;
    logic wr_w;
    logic upd_z;
    logic upd_c;
    logic upd_nh;
    logic z;
    logic c;
    logic nh;
    logic skip;
  } cdir_alu_t;
endpackage

//--- logic/cdir_alu.sv
// operation decode and arithmetic for one instruction word
`timescale 1ns/100ps
`default_nettype none
module cdir_alu
  import cdir_pkg::*;
(
  input wire logic [11:0] instr,
  input wire logic [7:0] w,
  input wire logic [7:0] f,
  input wire logic c_in,
  output cdir_alu_t alu
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bmask;

  always_comb begin
    alu = '0;
    sum = '0;
    nib = '0;
    bmask = 8'h01 << instr[7:5];
    if (instr[11:10] == 2'b00) begin
      alu.wr_f = instr[5];
      alu.wr_w = ~instr[5];
      alu.upd_z = 1'b1;
      case (instr[9:6])
        4'h0: begin
          alu.res = w;
          alu.wr_f = instr[5];
          alu.wr_w = 1'b0;
          alu.upd_z = 1'b0;
        end
        4'h1: alu.res = 8'h00;
        4'h2: begin
          sum = {1'b0, f} + {1'b0, ~w} + 9'h001;
          nib = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
          alu.res = sum[7:0];
          alu.upd_c = 1'b1;
          alu.upd_nh = 1'b1;
        end
        4'h3: alu.res = f - 8'h01;
        4'h4: alu.res = w | f;
        4'h5: alu.res = w & f;
        4'h6: alu.res = w ^ f;
        4'h7: begin
          sum = {1'b0, f} + {1'b0, w};
          nib = {1'b0, f[3:0]} + {1'b0, w[3:0]};
          alu.res = sum[7:0];
          alu.upd_c = 1'b1;
          alu.upd_nh = 1'b1;
        end
        4'h8: alu.res = f;
        4'h9: alu.res = ~f;
        4'ha: alu.res = f + 8'h01;
        4'hb: begin
          alu.res = f - 8'h01;
          alu.upd_z = 1'b0;
          alu.skip = (alu.res == 8'h00);
        end
        4'hc: begin
          alu.res = {c_in, f[7:1]};
          alu.upd_z = 1'b0;
          alu.upd_c = 1'b1;
        end
        4'hd: begin
          alu.res = {f[6:0], c_in};
          alu.upd_z = 1'b0;
          alu.upd_c = 1'b1;
        end
        4'he: begin
          alu.res = {f[3:0], f[7:4]};
          alu.upd_z = 1'b0;
        end
        default: begin
          alu.res = f + 8'h01;
          alu.upd_z = 1'b0;
          alu.skip = (alu.res == 8'h00);
        end
      endcase
      alu.c = (instr[9:6] == 4'hc) ? f[0] : (instr[9:6] == 4'hd) ? f[7] : sum[8];
      alu.nh = nib[4];
    end else if (instr[11:10] == 2'b01) begin
      case (instr[9:8])
        2'b00: begin
          alu.res = f & ~bmask;
          alu.wr_f = 1'b1;
        end
        2'b01: begin
          alu.res = f | bmask;
          alu.wr_f = 1'b1;
        end
        2'b10: alu.skip = ((f & bmask) == 8'h00);
        default: alu.skip = ((f & bmask) != 8'h00);
      endcase
    end else begin
      case (instr[11:8])
        4'h8, 4'hc: begin
          alu.res = instr[7:0];
          alu.wr_w = 1'b1;
        end
        4'hd: begin
          alu.res = w | instr[7:0];
          alu.wr_w = 1'b1;
          alu.upd_z = 1'b1;
        end
        4'he: begin
          alu.res = w & instr[7:0];
          alu.wr_w = 1'b1;
          alu.upd_z = 1'b1;
        end
        4'hf: begin
          alu.res = w ^ instr[7:0];
          alu.wr_w = 1'b1;
          alu.upd_z = 1'b1;
        end
        default: alu.res = 8'h00;
      endcase
    end
    alu.z = (alu.res == 8'h00);
  end
endmodule
`default_nettype wire

//--- logic/cdir_core.sv
// instruction execute core with indirect addressing and reset causes
`timescale 1ns/100ps
`default_nettype none
module cdir_core
  import cdir_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic external_clear_pin_n,
  input wire logic watchdog_timeout,
  input wire logic timer_tick,
  input wire logic [11:0] prog_word,
  input wire logic [2:0][7:0] port_pin,
  output logic [8:0] prog_addr,
  output logic [2:0][7:0] port_out,
  output logic [2:0][7:0] port_oe,
  output logic [7:0] status_flags,
  output logic [7:0] option_value,
  output logic core_sleeping,
  output logic watchdog_clear,
  output logic prescaler_clear
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cdir_state_t state_reg;
  logic [1:0] clr_sync_reg;
  logic [8:0] prog_addr_reg;
  logic flush_reg;
  logic [8:0] stack0_reg;
  logic [8:0] stack1_reg;
  logic [7:0] w_reg;
  logic [7:0] status_reg;
  logic [7:0] option_reg;
  logic [7:0] timer_reg;
  logic [6:0] ptr_reg;
  logic [7:0] ram_reg [RAM_DEPTH];
  logic [7:0] pin1_reg [PORT_COUNT];
  logic [7:0] pin2_reg [PORT_COUNT];
  logic [7:0] port_out_reg [PORT_COUNT];
  logic [7:0] port_oe_reg [PORT_COUNT];
  logic watchdog_clear_reg;
  logic prescaler_clear_reg;

  // ------------------------------------------------------------
  // decode and operand fetch
  // ------------------------------------------------------------
  logic [11:0] instr;
  logic soft_rst;
  logic from_sleep;
  logic exec;
  logic ind;
  logic ind_self;
  logic [4:0] fa;
  logic [1:0] bank;
  logic [6:0] ram_idx;
  logic [7:0] ptr_rd;
  logic [7:0] fval;
  logic fwr;
  logic is_call;
  logic is_goto;
  logic is_retlw;
  logic is_standby;
  logic is_kick;
  logic is_option;
  logic is_dir;
  logic pcl_wr;
  logic tmr_wr;
  cdir_alu_t alu;

  // a flushed slot executes as a no-operation
  assign instr = flush_reg ? OP_NOP : prog_word;
  assign soft_rst = clk_en && (!clr_sync_reg[1] || watchdog_timeout);
  assign from_sleep = (state_reg == CD_SLEEP);
  assign exec = clk_en && !soft_rst && (state_reg == CD_RUN);

  assign ind = (instr[4:0] == A_WIN);
  assign fa = ind ? ptr_reg[4:0] : instr[4:0];
  assign ind_self = ind && (ptr_reg[4:0] == A_WIN);
  assign bank = PTR_BANKED ? ptr_reg[6:5] : 2'b00;
  assign ram_idx = fa[4] ? 7'({1'b0, bank, fa[3:0]} + RAM_BANK_BASE) : {4'h0, fa[2:0]};
  // unimplemented pointer bits read as ones
  assign ptr_rd = PTR_BANKED ? {1'b1, ptr_reg} : {3'b111, ptr_reg[4:0]};

  always_comb begin
    case (fa)
      A_WIN: fval = 8'h00;
      A_TIMER: fval = timer_reg;
      A_PC_LOW: fval = prog_addr_reg[7:0];
      A_STATUS: fval = status_reg;
      A_PTR: fval = ptr_rd;
      // port reads see the pins, so read-modify-write uses pin levels
      5'h05, 5'h06, 5'h07: fval = pin2_reg[2'(fa - A_PORT0)];
      default: fval = ram_reg[ram_idx];
    endcase
  end

  cdir_alu u_alu (
    .instr(instr),
    .w(w_reg),
    .f(fval),
    .c_in(status_reg[ST_CARRY]),
    .alu(alu)
  );

  assign fwr = exec && alu.wr_f && !ind_self;
  assign is_call = (instr[11:8] == 4'h9);
  assign is_goto = (instr[11:9] == 3'b101);
  assign is_retlw = (instr[11:8] == 4'h8);
  assign is_standby = (instr == OP_STANDBY);
  assign is_kick = (instr == OP_KICK);
  assign is_option = (instr == OP_OPTION);
  assign is_dir = (instr[11:3] == 9'h000) && (instr[2:0] >= 3'd5);
  assign pcl_wr = fwr && (fa == A_PC_LOW);
  assign tmr_wr = fwr && (fa == A_TIMER);

  // ------------------------------------------------------------
  // synchroniser for the clear pin
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clr_sync_reg <= SYNC_RST;
    end else if (clk_en) begin
      clr_sync_reg <= {clr_sync_reg[0], external_clear_pin_n};
    end
  end

  // ------------------------------------------------------------
  // run and sleep
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= CD_RUN;
    end else if (soft_rst) begin
      state_reg <= CD_RUN;
    end else if (clk_en) begin
      case (state_reg)
        CD_RUN: begin
          if (exec && is_standby) begin
            state_reg <= CD_SLEEP;
          end
        end
        CD_SLEEP: state_reg <= CD_SLEEP;
        default: state_reg <= CD_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // program counter, prefetch flush and return stack
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prog_addr_reg <= RESET_VECTOR;
      flush_reg <= 1'b1;
      stack0_reg <= STACK_RST;
      stack1_reg <= STACK_RST;
    end else if (soft_rst) begin
      // wake from sleep restarts at the vector, never resumes
      prog_addr_reg <= RESET_VECTOR;
      flush_reg <= 1'b1;
    end else if (exec) begin
      prog_addr_reg <= prog_addr_reg + 9'h001;
      flush_reg <= alu.skip;
      if (is_goto) begin
        prog_addr_reg <= instr[8:0];
        flush_reg <= 1'b1;
      end else if (is_call) begin
        prog_addr_reg <= {1'b0, instr[7:0]};
        stack0_reg <= prog_addr_reg;
        stack1_reg <= stack0_reg;
        flush_reg <= 1'b1;
      end else if (is_retlw) begin
        prog_addr_reg <= stack0_reg;
        stack0_reg <= stack1_reg;
        flush_reg <= 1'b1;
      end else if (pcl_wr) begin
        prog_addr_reg <= {1'b0, alu.res};
        flush_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // accumulator
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      w_reg <= W_RST;
    end else if (exec && alu.wr_w) begin
      w_reg <= alu.res;
    end
  end

  // ------------------------------------------------------------
  // status flags and reset cause
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= STATUS_POR;
    end else if (soft_rst) begin
      status_reg[7:5] <= 3'b000;
      if (watchdog_timeout) begin
        status_reg[ST_TIMEOUT] <= 1'b0;
        status_reg[ST_POWERDOWN] <= !from_sleep;
      end else if (from_sleep) begin
        status_reg[ST_TIMEOUT] <= 1'b1;
        status_reg[ST_POWERDOWN] <= 1'b0;
      end
    end else if (exec) begin
      if (fwr && (fa == A_STATUS)) begin
        status_reg[7:5] <= alu.res[7:5];
        status_reg[2:0] <= alu.res[2:0];
      end
      // instruction flags override a direct write of the same bits
      if (alu.upd_z) begin
        status_reg[ST_ZERO] <= alu.z;
      end
      if (alu.upd_c) begin
        status_reg[ST_CARRY] <= alu.c;
      end
      if (alu.upd_nh) begin
        status_reg[ST_NIBBLE] <= alu.nh;
      end
      if (is_kick) begin
        status_reg[ST_TIMEOUT] <= 1'b1;
        status_reg[ST_POWERDOWN] <= 1'b1;
      end else if (is_standby) begin
        status_reg[ST_TIMEOUT] <= 1'b1;
        status_reg[ST_POWERDOWN] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // pointer, timer and option
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= PTR_RST;
      timer_reg <= TIMER_RST;
      option_reg <= OPTION_RST;
    end else if (soft_rst) begin
      option_reg <= OPTION_RST;
    end else if (clk_en) begin
      if (fwr && (fa == A_PTR)) begin
        ptr_reg <= PTR_BANKED ? alu.res[6:0] : {2'b11, alu.res[4:0]};
      end
      if (tmr_wr) begin
        timer_reg <= alu.res;
      end else if (timer_tick) begin
        timer_reg <= timer_reg + 8'h01;
      end
      if (exec && is_option) begin
        option_reg <= w_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // general registers, left out of every reset
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (fwr && (fa >= A_RAM)) begin
      ram_reg[ram_idx] <= alu.res;
    end
  end

  // ------------------------------------------------------------
  // ports
  // ------------------------------------------------------------
  for (genvar i = 0; i < PORT_COUNT; i++) begin : g_port
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        pin1_reg[i] <= LATCH_RST;
        pin2_reg[i] <= LATCH_RST;
        port_out_reg[i] <= LATCH_RST;
        port_oe_reg[i] <= ~DIR_RST;
      end else if (clk_en) begin
        pin1_reg[i] <= port_pin[i];
        pin2_reg[i] <= pin1_reg[i];
        if (soft_rst) begin
          port_oe_reg[i] <= ~DIR_RST;
        end else if (exec && is_dir && (instr[1:0] == 2'(i + 1))) begin
          // a direction bit of one releases the pin
          port_oe_reg[i] <= ~w_reg;
        end
        if (fwr && (fa == 5'(A_PORT0 + 5'(i)))) begin
          port_out_reg[i] <= alu.res;
        end
      end
    end
    assign port_out[i] = port_out_reg[i];
    assign port_oe[i] = port_oe_reg[i];
  end

  // ------------------------------------------------------------
  // side-effect pulses
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_clear_reg <= 1'b0;
      prescaler_clear_reg <= 1'b0;
    end else if (clk_en) begin
      watchdog_clear_reg <= exec && (is_kick || is_standby);
      prescaler_clear_reg <= tmr_wr && !option_reg[OPT_PRESCALE_WDT];
    end
  end

  assign prog_addr = prog_addr_reg;
  assign status_flags = status_reg;
  assign option_value = option_reg;
  assign core_sleeping = (state_reg == CD_SLEEP);
  assign watchdog_clear = watchdog_clear_reg;
  assign prescaler_clear = prescaler_clear_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_skip_taken;
    exec && alu.skip;
  endsequence

  sequence seq_flushed_step;
    flush_reg && (prog_addr_reg == $past(prog_addr_reg) + 9'h001);
  endsequence

  chk_skip_flush: assert property (seq_skip_taken |=> seq_flushed_step)
    else $error("taken skip did not flush the next word");
  chk_skip_flags: assert property (
    seq_skip_taken and (fa != A_STATUS) |=> $stable(status_reg))
    else $error("skip operation changed the status flags");
  chk_self_zero: assert property (ind_self |-> fval == 8'h00)
    else $error("window read through itself not zero");
  chk_self_nowrite: assert property (
    exec && ind_self && alu.wr_f |=> $stable(ptr_reg) && $stable(timer_reg))
    else $error("window write through itself stored data");
  chk_xor_literal: assert property (
    exec && (instr[11:8] == 4'hf) |=> (w_reg == ($past(w_reg) ^ $past(instr[7:0])))
    && (status_reg[1:0] == $past(status_reg[1:0]))
    && (status_reg[ST_ZERO] == (w_reg == 8'h00)))
    else $error("xor literal result or flags wrong");
  chk_dest_w: assert property (
    exec && (instr[11:10] == 2'b00) && (instr[9:6] != 4'h0) && !instr[5]
    |=> w_reg == $past(alu.res))
    else $error("destination zero did not load the accumulator");
  chk_pc_page: assert property (exec && (is_call || pcl_wr) |=> !prog_addr_reg[8] && flush_reg)
    else $error("counter bit eight not cleared on write");
  chk_wdt_wake: assert property (
    soft_rst && watchdog_timeout && from_sleep |=> (status_reg[4:3] == 2'b00)
    && (state_reg == CD_RUN) && (prog_addr_reg == RESET_VECTOR))
    else $error("watchdog wake did not reset with flags 00");
  chk_clear_run: assert property (
    soft_rst && !watchdog_timeout && !from_sleep
    |=> (status_reg[4:0] == $past(status_reg[4:0])) && (status_reg[7:5] == 3'b000))
    else $error("clear pin reset while running changed flags");
  chk_dir_load: assert property (
    exec && is_dir && (instr[2:0] == 3'd6) |=> port_oe_reg[1] == ~$past(w_reg))
    else $error("direction load missed port b");
  chk_tmr_clear: assert property (
    tmr_wr && !option_reg[OPT_PRESCALE_WDT] |=> prescaler_clear_reg)
    else $error("timer write did not clear the prescaler");
endmodule
`default_nettype wire

//--- test/cdir_prog_mem.sv
// program memory model feeding twelve-bit words to the core
`timescale 1ns/100ps
`default_nettype none
module cdir_prog_mem (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic [8:0] prog_addr,
  output logic [11:0] prog_word
);
  logic [11:0] mem [512];
  // address taken at each enabled edge, word shown until the next one
  always @(posedge sys_clk) begin
    if (clk_en) begin
      prog_word <= mem[prog_addr];
    end
  end
  task automatic put(input logic [8:0] a, input logic [11:0] d);
    mem[a] = d;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench: indirect access, banks, skips, rotate, reset causes
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cdir_pkg::*;
  logic sys_clk, resetn, clk_en, clr_n, wdt, tick;
  logic [2:0][7:0] pins, port_out, port_oe;
  logic [11:0] prog_word;
  logic [8:0] prog_addr;
  logic [7:0] status_flags;
  logic [7:0] opt;
  logic core_sleeping, wdc, psc;
  bit wd_seen = 1'b0;
  bit ps_seen = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  // window, xor, banking, self-window access
  // tail: option 00 hands the prescaler to the timer, then a timer clear
  logic [11:0] prog_a [35] = '{12'hc10, 12'h028, 12'hc0a, 12'h029, 12'hc08, 12'h024,
    12'h200, 12'h025, 12'h2a4, 12'h200, 12'hfaf, 12'h026, 12'h1a9, 12'h209, 12'h027,
    12'hc30, 12'h024, 12'hc77, 12'h020, 12'hc10, 12'h024, 12'h060, 12'hc30, 12'h024,
    12'h200, 12'h007, 12'h064, 12'hc55, 12'h020, 12'h200, 12'h005, 12'hc00, 12'h002,
    12'h061, 12'ha22};
  // skips, rotate through carry, direction load, standby
  logic [11:0] prog_b [15] = '{12'hc01, 12'h030, 12'h2f0, 12'h025, 12'hc81, 12'h031,
    12'h503, 12'h351, 12'h026, 12'h703, 12'h027, 12'hc0f, 12'h006, 12'h003, 12'ha0e};
  cdir_core dut_u (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .external_clear_pin_n(clr_n), .watchdog_timeout(wdt), .timer_tick(tick),
    .prog_word(prog_word), .port_pin(pins), .prog_addr(prog_addr), .port_out(port_out),
    .port_oe(port_oe), .status_flags(status_flags), .option_value(opt),
    .core_sleeping(core_sleeping), .watchdog_clear(wdc), .prescaler_clear(psc));
  // one-cycle pulses are caught in sticky flags
  always @(posedge sys_clk) begin
    if (wdc === 1'b1) wd_seen <= 1'b1;
    if (psc === 1'b1) ps_seen <= 1'b1;
  end
  cdir_prog_mem mem_u (.sys_clk(sys_clk), .clk_en(clk_en), .prog_addr(prog_addr),
    .prog_word(prog_word));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_until(input bit slp, input logic [8:0] a);
    int k;
    k = 0;
    while (!(slp ? core_sleeping === 1'b1 : prog_addr === a) && k < 200) begin
      step(1);
      k++;
    end
    if (k >= 200) n_fail++;
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    clr_n = 1'b1;
    wdt = 1'b0;
    tick = 1'b0;
    pins = 24'h5a3c96;
    foreach (prog_a[i]) mem_u.put(9'(i), prog_a[i]);
    mem_u.put(9'h1ff, 12'ha00);
    step(12);
    chk("power-on status", 9'h003, {4'h0, status_flags[7:3]});
    chk("reset address", 9'h1ff, prog_addr);
    chk("power-on option", 9'h0ff, {1'b0, opt});
    resetn = 1'b1;
    wait_until(1'b0, 9'h020);
    step(4);
    chk("window read", 9'h010, {1'b0, port_out[0]});
    chk("xor literal", 9'h0a5, {1'b0, port_out[1]});
    chk("xor file to file", 9'h0af, {1'b0, port_out[2]});
    chk("bank select", 9'h088, {1'b0, port_oe[2]});
    chk("self window read", 9'h0ff, {1'b0, port_oe[0]});
    chk("zero flag", 9'h001, {8'h0, status_flags[ST_ZERO]});
    chk("option load", 9'h000, {1'b0, opt});
    chk("prescaler clear", 9'h001, {8'h0, ps_seen});
    foreach (prog_b[i]) mem_u.put(9'(i), prog_b[i]);
    wdt = 1'b1;
    step(1);
    wdt = 1'b0;
    chk("watchdog run cause", 9'h001, {4'h0, status_flags[7:3]});
    chk("watchdog restart", 9'h1ff, prog_addr);
    chk("watchdog option", 9'h0ff, {1'b0, opt});
    wait_until(1'b1, 9'h000);
    step(2);
    chk("standby flags", 9'h002, {7'h0, status_flags[4:3]});
    chk("standby kick pulse", 9'h001, {8'h0, wd_seen});
    chk("decrement skip", 9'h010, {1'b0, port_out[0]});
    chk("rotate left", 9'h003, {1'b0, port_out[1]});
    chk("bit test skip", 9'h0af, {1'b0, port_out[2]});
    chk("direction load", 9'h0f0, {1'b0, port_oe[1]});
    clr_n = 1'b0;
    step(4);
    chk("clear wake cause", 9'h002, {7'h0, status_flags[4:3]});
    chk("clear wake state", 9'h000, {8'h0, core_sleeping});
    clr_n = 1'b1;
    wait_until(1'b1, 9'h000);
    step(2);
    wdt = 1'b1;
    step(1);
    wdt = 1'b0;
    chk("watchdog wake cause", 9'h000, {7'h0, status_flags[4:3]});
    chk("watchdog wake state", 9'h000, {8'h0, core_sleeping});
    chk("wake restart", 9'h1ff, prog_addr);
    step(3);
    clr_n = 1'b0;
    step(4);
    chk("clear run cause", 9'h000, {7'h0, status_flags[4:3]});
    clr_n = 1'b1;
    step(2);
    wrap_up();
  end
endmodule
`default_nettype wire
